// ==== sim/mpm_gate_drv.sv ====
`timescale 1ns/1ps
module mpm_gate_drv (
  input wire logic i_clock,
  input wire logic [5:0] i_pin_out,
  input wire logic [5:0] i_pin_oe_n,
  input wire logic [1:0] i_off,
  output logic [5:0] o_pin_lvl,
  output logic [5:0] o_on,
  output logic o_shoot
);
  logic [5:0] float_reg = 6'h2A;
  ////////////////////////////////////////////////////////////////////////////
  // Released pins float, shown as a pattern that changes every cycle
  always_ff @(posedge i_clock)
  begin
    float_reg <= ~float_reg;
  end
  assign o_pin_lvl = (i_pin_out & ~i_pin_oe_n) | (float_reg & i_pin_oe_n);
  assign o_on = (o_pin_lvl ^ {3{i_off}}) & ~i_pin_oe_n;
  // Both transistors of one leg on at once
  assign o_shoot = (o_on[0] & o_on[1]) | (o_on[2] & o_on[3])
    | (o_on[4] & o_on[5]);
endmodule : mpm_gate_drv

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic i_clock, rst, hsel, hwrite, hreadyout, hresp, ovc, irq, trig, sh;
  logic shoot;
  mpm_pkg::mpm_opt_t opt;
  logic [31:0] haddr, hwdata, hrdata, rdat, got;
  logic [1:0] htrans, fault_n, offl;
  logic [5:0] pin_in, pin_out, oe_n, on;
  logic [31:0] exp_q[$];
  int fails = 0;
  int n_compared = 0;
  int nshoot = 0;
  int dty;
  event ev_res;

  assign offl = {opt.lo_off, opt.hi_off};
  mpm_modulator uut (.i_clock(i_clock), .i_rst(rst), .i_options(opt),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(oe_n),
    .i_fault_n(fault_n), .i_overcurrent(ovc), .o_reload_irq(irq),
    .o_conv_trig(trig), .o_sample_hold(sh));
  mpm_gate_drv drv (.i_clock(i_clock), .i_pin_out(pin_out),
    .i_pin_oe_n(oe_n), .i_off(offl), .o_pin_lvl(pin_in), .o_on(on),
    .o_shoot(shoot));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic post(input logic [31:0] g);
    got = g;
    ->ev_res;
    #1;
  endtask : post

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    exp_q.push_back(e);
    post(g);
  endtask : chk

  // One single word transfer, read data kept in rdat
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    rdat = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
    post(rdat);
  endtask : rd

  // On-cycles of one pin and trigger pulses over a window
  task automatic meas(input int b, input int n, input int e_on,
    input int e_tr);
    int c_on;
    int c_tr;
    c_on = 0;
    c_tr = 0;
    exp_q.push_back(32'(e_on));
    exp_q.push_back(32'(e_tr));
    repeat (2) @(posedge i_clock);
    repeat (n)
    begin
      @(negedge i_clock);
      if (on[b] === 1'b1) c_on++;
      if (trig === 1'b1) c_tr++;
      if (shoot !== 1'b0) nshoot++;
    end
    post(32'(c_on));
    post(32'(c_tr));
  endtask : meas

  // Sample/hold and reload pulse cycles over a window
  task automatic meas_sh(input int n, input int e_sh, input int e_irq);
    int c_sh;
    int c_irq;
    c_sh = 0;
    c_irq = 0;
    exp_q.push_back(32'(e_sh));
    exp_q.push_back(32'(e_irq));
    repeat (n)
    begin
      @(negedge i_clock);
      if (sh === 1'b1) c_sh++;
      if (irq === 1'b1) c_irq++;
    end
    post(32'(c_sh));
    post(32'(c_irq));
  endtask : meas_sh

  task automatic do_reset(input logic m);
    @(posedge i_clock);
    rdat = $urandom();
    rst <= 1'b1;
    opt <= {m, rdat[1:0]};
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    #1;
    chk({26'h0, oe_n}, 32'h3F);
    repeat (3) @(posedge i_clock);
    #1;
    chk({26'h0, pin_out}, {26'h0, {3{offl}}});
    chk({26'h0, oe_n}, m ? 32'h0 : 32'h3F);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever
    begin
      @(ev_res);
      n_compared++;
      if (got !== exp_q[0])
      begin
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge i_clock);
    fails++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    opt = 3'h0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fault_n = 2'h3;
    ovc = 1'b0;
    dty = $urandom(32'h1771);
    do_reset(1'b0);
    do_reset(1'b1);
    rd(mpm_pkg::OFF_RELOAD, 32'hFFF);
    rd(8'h3C, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(mpm_pkg::OFF_RELOAD, 32'hF);
    wr(mpm_pkg::OFF_DEAD, 32'h3);
    wr(mpm_pkg::OFF_DUTY0, 32'h8);
    wr(mpm_pkg::OFF_CTRL0, 32'h2);
    wr(mpm_pkg::OFF_CTRL0, 32'h5);
    repeat (40) @(posedge i_clock);
    // Complementary pair, period 16, deadband 3 cycles
    meas(0, 64, 20, 4);
    meas(1, 64, 20, 4);
    wr(mpm_pkg::OFF_OVR, 32'h41);
    meas(0, 64, 0, 4);
    meas(1, 64, 20, 4);
    wr(mpm_pkg::OFF_OVR, 32'h0);
    wr(mpm_pkg::OFF_DUTY0, 32'hC);
    repeat (40) @(posedge i_clock);
    meas(0, 64, 20, 4);
    wr(mpm_pkg::OFF_CTRL0, 32'h7);
    repeat (40) @(posedge i_clock);
    meas(0, 64, 36, 4);
    rd(mpm_pkg::OFF_CTRL0, 32'h5);
    wr(mpm_pkg::OFF_SH, 32'h1);
    wr(mpm_pkg::OFF_CTRL0, 32'h7);
    meas_sh(64, 36, 1);
    wr(mpm_pkg::OFF_MINPW, 32'h2);
    repeat (40) @(posedge i_clock);
    meas(1, 64, 0, 4);
    chk(32'(nshoot), 32'h0);
    wr(mpm_pkg::OFF_MINPW, 32'h0);
    // Independent outputs under every prescale value
    for (int p = 0; p < 4; p++)
    begin
      dty = 1 + ($urandom() % 15);
      wr(mpm_pkg::OFF_CTRL1, 32'h10 | 32'(p));
      wr(mpm_pkg::OFF_DUTY0, 32'hFFFB);
      wr(mpm_pkg::OFF_DUTY0 + 8'h08, 32'h10);
      wr(mpm_pkg::OFF_DUTY0 + 8'h10, 32'(dty));
      wr(mpm_pkg::OFF_CTRL0, 32'h7);
      repeat (300) @(posedge i_clock);
      meas(0, 64 << p, 0, 4);
      meas(2, 64 << p, 64 << p, 4);
      meas(4, 64 << p, (dty * 4) << p, 4);
    end
    // Centre mode, period 30, trigger at end and top
    wr(mpm_pkg::OFF_CTRL1, 32'h110);
    wr(mpm_pkg::OFF_CTRL0, 32'h7);
    repeat (300) @(posedge i_clock);
    meas(2, 120, 120, 8);
    chk(32'(nshoot), 32'h0);
    print_verdict();
  end
endmodule : tb_top

// ==== src/mpm_dead_shaper.sv ====
`timescale 1ns/1ps
module mpm_dead_shaper #(
  parameter int unsigned DB_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_level,
  input wire logic [DB_W-1:0] i_dead,
  output logic o_level
);

  logic [DB_W-1:0] cnt_reg;
  logic lvl_reg;

  wire done = cnt_reg >= i_dead;

  // Assertion delayed by dead time, release at once
  always_ff @(posedge i_clock)
  begin
    if (i_rst | ~i_level)
    begin
      cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end
    else if (done)
      lvl_reg <= 1'b1;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign o_level = lvl_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_start;
    $rose(i_level) ##0 (i_dead > 1);
  endsequence

  property p_dead_hold;
    s_start |=> !o_level ##1 !o_level;
  endproperty
  a_dead_hold: assert property (p_dead_hold)
    else $error("output asserted inside dead time");

  property p_cut;
    !i_level |=> !o_level;
  endproperty
  a_cut: assert property (p_cut)
    else $error("output not released with its level");

  property p_zero_dead;
    i_level && i_dead == 0 |=> o_level;
  endproperty
  a_zero_dead: assert property (p_zero_dead)
    else $error("zero dead time delayed the output");

endmodule : mpm_dead_shaper

// ==== src/mpm_modulator.sv ====
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Operation
// - six outputs in three high/low pairs
// - option value sets off level per side
// - options fixed, software cannot change
// - no motor option: pins stay high-impedance
// - motor option: high-z in reset, then off
// - timing values buffered until reload event
// - reload every 1, 2, 4, 8 periods
// - ready bit arms transfer at next reload, at once if disabled
// - counter clock divided by 1/2/4/8
// - edge mode counts up, wraps to zero
// - center mode counts up then down
// - signed 16-bit duty against 12-bit count
// - duty <=0 off, above reload on
// - independent mode: own duty, no deadband
// - complementary: high duty, low complement
// - polarity bit swaps starting states
// - manual force-off per single channel
// - deadband counts system clocks, 0..255
// - both off in deadband, period unchanged
// - suppress pulses below minimum width
// - minimum width judged after deadband
// - converter trigger at end, also center
// - sample/hold on any or all outputs
// - reload pulse at a reload with ready bit set
// - fault forces outputs off, counter runs
module mpm_modulator (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire mpm_pkg::mpm_opt_t i_options,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [5:0] i_pin_in,
  output logic [5:0] o_pin_out,
  output logic [5:0] o_pin_oe_n,
  input wire logic [1:0] i_fault_n,
  input wire logic i_overcurrent,
  output logic o_reload_irq,
  output logic o_conv_trig,
  output logic o_sample_hold
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic wr_pend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_data;

  wire addr_acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);
  wire [7:0] ra = i_haddr[7:0];
  wire [7:0] rd_off = ra - mpm_pkg::OFF_DUTY0;
  wire [7:0] wr_off = waddr_reg - mpm_pkg::OFF_DUTY0;
  wire rd_duty = (ra >= mpm_pkg::OFF_DUTY0) &
    (ra < mpm_pkg::OFF_DUTY_END) & (ra[1:0] == 2'h0);
  wire wr_duty = wr_pend_reg & (waddr_reg >= mpm_pkg::OFF_DUTY0) &
    (waddr_reg < mpm_pkg::OFF_DUTY_END) & (waddr_reg[1:0] == 2'h0);
  wire wr_c0 = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_CTRL0);
  wire wr_c1 = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_CTRL1);
  wire wr_rl = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_RELOAD);
  wire wr_db = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_DEAD);
  wire wr_mp = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_MINPW);
  wire wr_ov = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_OVR);
  wire wr_sh = wr_pend_reg & (waddr_reg == mpm_pkg::OFF_SH);

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_acc & i_hwrite;
      waddr_reg <= ra;
      if (addr_acc & ~i_hwrite)
        hrdata_reg <= rd_data;
    end
  end

  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Registers and buffered copies
  mpm_pkg::mpm_opt_t opt_reg;
  mpm_pkg::mpm_tmg_t tmg_reg;
  logic [6:0] ctrl0_reg;
  logic [8:0] ctrl1_reg;
  logic [11:0] reload_buf_reg;
  logic [7:0] dead_reg;
  logic [7:0] minpw_reg;
  logic [6:0] ovr_reg;
  logic [7:0] sh_reg;
  logic [15:0] duty_buf [6];
  logic [15:0] duty_act [6];

  wire en = ctrl0_reg[mpm_pkg::C0_EN];
  wire ready = ctrl0_reg[mpm_pkg::C0_READY];
  wire [1:0] relf = ctrl1_reg[mpm_pkg::C1_RELF +: 2];
  wire indep = ctrl1_reg[mpm_pkg::C1_IND];
  wire [2:0] pol = ctrl1_reg[mpm_pkg::C1_POL +: 3];
  wire reload_evt;
  wire xfer = ready & (reload_evt | ~en);

  // Options caught only while reset is held
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      opt_reg <= i_options;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ctrl0_reg <= mpm_pkg::CTRL0_RST;
      ctrl1_reg <= mpm_pkg::CTRL1_RST;
      reload_buf_reg <= mpm_pkg::RELOAD_RST;
      dead_reg <= mpm_pkg::DEAD_RST;
      minpw_reg <= mpm_pkg::MINPW_RST;
      ovr_reg <= mpm_pkg::OVR_RST;
      sh_reg <= mpm_pkg::SH_RST;
    end
    else
    begin
      if (wr_c0)
        ctrl0_reg <= i_hwdata[6:0];
      else if (xfer)
        ctrl0_reg[mpm_pkg::C0_READY] <= 1'b0;
      if (wr_c1)
        ctrl1_reg <= i_hwdata[8:0];
      if (wr_rl)
        reload_buf_reg <= i_hwdata[11:0];
      if (wr_db)
        dead_reg <= i_hwdata[7:0];
      if (wr_mp)
        minpw_reg <= i_hwdata[7:0];
      if (wr_ov)
        ovr_reg <= i_hwdata[6:0];
      if (wr_sh)
        sh_reg <= i_hwdata[7:0];
    end
  end

  // Buffer and active copy of the duty values
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      tmg_reg <= '{prescale_select: 2'h0, reload: mpm_pkg::RELOAD_RST, center: 1'b0};
      for (int k = 0; k < 6; k++)
      begin
        duty_buf[k] <= mpm_pkg::DUTY_RST;
        duty_act[k] <= mpm_pkg::DUTY_RST;
      end
    end
    else
    begin
      if (wr_duty)
        duty_buf[wr_off[4:2]] <= i_hwdata[15:0];
      if (xfer)
      begin
        tmg_reg.prescale_select <= ctrl1_reg[mpm_pkg::C1_PRESCALE_SELECT +: 2];
        tmg_reg.reload <= reload_buf_reg;
        tmg_reg.center <= ctrl1_reg[mpm_pkg::C1_CTR];
        for (int k = 0; k < 6; k++)
          duty_act[k] <= duty_buf[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master counter
  logic [11:0] cnt_reg;
  logic dir_up_reg;
  logic [2:0] div_reg;
  logic [2:0] rl_reg;

  wire [1:0] prescale_select = tmg_reg.prescale_select;
  wire [11:0] rel = tmg_reg.reload;
  wire center = tmg_reg.center;
  wire [2:0] prescale_select_mask = {prescale_select == 2'h3, prescale_select[1], |prescale_select};
  wire [2:0] relf_mask = {relf == 2'h3, relf[1], |relf};
  wire tick = en & (div_reg == prescale_select_mask);
  wire at_top = cnt_reg == rel;
  wire at_zero = cnt_reg == 12'h000;
  wire per_end = tick & (center ? (~dir_up_reg & at_zero) : at_top);
  wire mid_evt = tick & center & dir_up_reg & at_top;
  assign reload_evt = per_end & (rl_reg == relf_mask);
  wire turn = tick & center & (dir_up_reg ? at_top : at_zero);
  wire [11:0] cnt_up = cnt_reg + 12'h001;
  wire [11:0] cnt_dn = cnt_reg - 12'h001;
  wire [11:0] cnt_ctr = (dir_up_reg ^ turn) ? cnt_up : cnt_dn;
  wire [11:0] cnt_edge = at_top ? 12'h000 : cnt_up;
  wire [11:0] cnt_next = ~en ? 12'h000 : ~tick ? cnt_reg :
    center ? cnt_ctr : cnt_edge;

  always_ff @(posedge i_clock)
  begin
    if (i_rst | ~en)
    begin
      cnt_reg <= 12'h000;
      dir_up_reg <= 1'b1;
      div_reg <= 3'h0;
      rl_reg <= 3'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      dir_up_reg <= dir_up_reg ^ turn;
      div_reg <= tick ? 3'h0 : div_reg + 3'h1;
      if (per_end)
        rl_reg <= reload_evt ? 3'h0 : rl_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin and fault synchronisers
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [2:0] flt_s1_reg;
  logic [2:0] flt_s2_reg;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      flt_s1_reg <= 3'h3;
      flt_s2_reg <= 3'h3;
    end
    else
    begin
      pin_s1_reg <= i_pin_in;
      pin_s2_reg <= pin_s1_reg;
      flt_s1_reg <= {i_overcurrent, i_fault_n};
      flt_s2_reg <= flt_s1_reg;
    end
  end

  wire [1:0] fen = ctrl0_reg[mpm_pkg::C0_FEN +: 2];
  wire fault_act = (|(fen & ~flt_s2_reg[1:0])) |
    (ctrl0_reg[mpm_pkg::C0_OCEN] & flt_s2_reg[2]) |
    ctrl0_reg[mpm_pkg::C0_SWOFF];

  ////////////////////////////////////////////////////////////////////////
  // Channels
  wire [7:0] dead_eff = indep ? 8'h00 : dead_reg;
  wire [13:0] tot = center ? {1'b0, rel, 1'b0} : {2'h0, rel} + 14'h0001;
  wire [16:0] thr = ({9'h000, minpw_reg} << prescale_select) + {9'h000, dead_eff};
  wire [5:0] off_lvl = {3{opt_reg.lo_off, opt_reg.hi_off}};
  wire ovr_en = ovr_reg[mpm_pkg::OV_EN];
  logic [5:0] cmp_vec;
  logic [5:0] on_vec;
  logic [5:0] off_vec;

  for (genvar i = 0; i < 6; i++)
  begin : g_ch
    localparam int unsigned PAIR = i / 2;
    localparam logic IS_LO = (i % 2) == 1;
    wire [15:0] d = indep ? duty_act[i] : duty_act[PAIR * 2];
    wire pos = ~d[15] & (d != 16'h0000);
    wire over = pos & (d[14:0] > {3'h0, rel});
    wire [12:0] w = ~pos ? 13'h0000 : over ?
      {1'b0, rel} + 13'h0001 : d[12:0];
    wire [13:0] act_c = (w == 13'h0000) ? 14'h0000 :
      over ? {1'b0, rel, 1'b0} : {w, 1'b0} - 14'h0001;
    wire [13:0] act = center ? act_c : {1'b0, w};
    wire [13:0] rest = tot - act;
    wire short_a = (act != 14'h0000) &
      (({3'h0, act} << prescale_select) < thr);
    wire short_r = (rest != 14'h0000) &
      (({3'h0, rest} << prescale_select) < thr);
    wire shaped;
    assign cmp_vec[i] = $signed({4'h0, cnt_reg}) < $signed(d);
    wire cmpf = ~short_a & (short_r | cmp_vec[i]);
    // Low side is a complement only when paired
    wire lvl = cmpf ^ pol[PAIR] ^ (IS_LO & ~indep);

    mpm_dead_shaper #(.DB_W(mpm_pkg::DB_W)) u_shaper (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(lvl & en),
      .i_dead(dead_eff),
      .o_level(shaped)
    );

    assign off_vec[i] = ~en | fault_act | (ovr_en & ovr_reg[i]);
    assign on_vec[i] = shaped & ~off_vec[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive
  mpm_pkg::mpm_ostate_t ostate_reg;
  logic [5:0] out_reg;
  logic irq_reg;
  logic trig_reg;
  logic hold_reg;

  wire [5:0] sh_sel = sh_reg[5:0];
  wire hold_any = |(sh_sel & on_vec);
  wire hold_all = ((sh_sel & on_vec) == sh_sel) & (|sh_sel);
  wire hold = ~sh_reg[mpm_pkg::SH_SMP] &
    (sh_reg[mpm_pkg::SH_ALL] ? hold_all : hold_any);

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ostate_reg <= mpm_pkg::OS_HIZ;
      out_reg <= 6'h00;
      irq_reg <= 1'b0;
      trig_reg <= 1'b0;
      hold_reg <= 1'b0;
    end
    else
    begin
      ostate_reg <= opt_reg.motor_en ?
        mpm_pkg::OS_DRIVE : mpm_pkg::OS_HIZ;
      out_reg <= on_vec ^ off_lvl;
      irq_reg <= reload_evt & ready;
      trig_reg <= ctrl0_reg[mpm_pkg::C0_TRIG] &
        (per_end | mid_evt);
      hold_reg <= hold;
    end
  end

  assign o_pin_out = out_reg;
  assign o_pin_oe_n = {6{ostate_reg == mpm_pkg::OS_HIZ}};
  assign o_reload_irq = irq_reg;
  assign o_conv_trig = trig_reg;
  assign o_sample_hold = hold_reg;

  assign rd_data =
    (ra == mpm_pkg::OFF_CTRL0) ? {25'h0, ctrl0_reg} :
    (ra == mpm_pkg::OFF_CTRL1) ? {23'h0, ctrl1_reg} :
    (ra == mpm_pkg::OFF_RELOAD) ? {20'h0, reload_buf_reg} :
    (ra == mpm_pkg::OFF_DEAD) ? {24'h0, dead_reg} :
    (ra == mpm_pkg::OFF_MINPW) ? {24'h0, minpw_reg} :
    (ra == mpm_pkg::OFF_OVR) ? {25'h0, ovr_reg} :
    (ra == mpm_pkg::OFF_SH) ? {24'h0, sh_reg} :
    (ra == mpm_pkg::OFF_STAT) ?
      {12'h0, fault_act, dir_up_reg, pin_s2_reg, cnt_reg} :
    rd_duty ? {16'h0, duty_buf[rd_off[4:2]]} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_hiz_in_reset;
    @(posedge i_clock) disable iff (1'b0) i_rst |=> o_pin_oe_n == 6'h3F;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset)
    else $error("pins driven during reset");

  property p_drive_after;
    @(posedge i_clock) $fell(i_rst) && opt_reg.motor_en
      |=> o_pin_oe_n == 6'h00 && o_pin_out == off_lvl;
  endproperty
  a_drive_after: assert property (p_drive_after)
    else $error("pins not at off level after reset");

  property p_no_motor;
    !opt_reg.motor_en |=> o_pin_oe_n == 6'h3F;
  endproperty
  a_no_motor: assert property (p_no_motor)
    else $error("pins driven without motor option");

  property p_ready_clear;
    xfer && !wr_c0 |=> !ctrl0_reg[mpm_pkg::C0_READY];
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready bit not cleared by transfer");

  property p_reload_pulse;
    reload_evt && ready |=> o_reload_irq ##1 !o_reload_irq;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse)
    else $error("reload pulse missing");

  property p_trigger;
    ctrl0_reg[mpm_pkg::C0_TRIG] && (per_end || mid_evt) |=> o_conv_trig;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("converter trigger missing");

  property p_force_off;
    ovr_en && ovr_reg[0] |=> o_pin_out[0] == opt_reg.hi_off;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("forced channel not at off level");

  property p_fault_off;
    fault_act |=> o_pin_out == off_lvl;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault did not force off levels");

  sequence s_edge_top;
    tick && !center && at_top;
  endsequence

  property p_edge_wrap;
    s_edge_top |=> cnt_reg == 12'h000;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap)
    else $error("edge counter did not wrap");

  sequence s_ctr_top;
    tick && center && dir_up_reg && at_top && rel != 12'h000;
  endsequence

  property p_ctr_turn;
    s_ctr_top |=> !dir_up_reg && cnt_reg == $past(cnt_reg) - 12'h001;
  endproperty
  a_ctr_turn: assert property (p_ctr_turn)
    else $error("center counter did not turn down");

  property p_neg_duty;
    duty_act[0][15] |-> !cmp_vec[0];
  endproperty
  a_neg_duty: assert property (p_neg_duty)
    else $error("negative duty matched the count");

endmodule : mpm_modulator

// ==== src/mpm_pkg.sv ====
package mpm_pkg;

  localparam int unsigned CNT_W = 12;
  localparam int unsigned DUTY_W = 16;
  localparam int unsigned DB_W = 8;
  localparam int unsigned NCH = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_DEAD = 8'h0C;
  localparam logic [7:0] OFF_MINPW = 8'h10;
  localparam logic [7:0] OFF_OVR = 8'h14;
  localparam logic [7:0] OFF_SH = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_DUTY0 = 8'h20;
  localparam logic [7:0] OFF_DUTY_END = 8'h38;

  // modulator_control_0 fields
  localparam int unsigned C0_EN = 0;
  localparam int unsigned C0_READY = 1;
  localparam int unsigned C0_TRIG = 2;
  localparam int unsigned C0_SWOFF = 3;
  localparam int unsigned C0_FEN = 4;
  localparam int unsigned C0_OCEN = 6;

  // modulator_control_1 fields
  localparam int unsigned C1_PRESCALE_SELECT = 0;
  localparam int unsigned C1_RELF = 2;
  localparam int unsigned C1_IND = 4;
  localparam int unsigned C1_POL = 5;
  localparam int unsigned C1_CTR = 8;

  // Override and sample/hold fields
  localparam int unsigned OV_EN = 6;
  localparam int unsigned SH_ALL = 6;
  localparam int unsigned SH_SMP = 7;

  // Values after reset
  localparam logic [6:0] CTRL0_RST = 7'h00;
  localparam logic [8:0] CTRL1_RST = 9'h000;
  localparam logic [11:0] RELOAD_RST = 12'hFFF;
  localparam logic [7:0] DEAD_RST = 8'h00;
  localparam logic [7:0] MINPW_RST = 8'h00;
  localparam logic [6:0] OVR_RST = 7'h00;
  localparam logic [7:0] SH_RST = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  typedef struct packed {
    logic motor_en;
    logic hi_off;
    logic lo_off;
  } mpm_opt_t;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic [11:0] reload;
    logic center;
  } mpm_tmg_t;

  typedef enum logic {OS_HIZ, OS_DRIVE} mpm_ostate_t;

endpackage : mpm_pkg
